/* rtl/link_port.sv */
// register access port: link side on link_clk, toggle handshake to clk_sys
// assumes link requests are dropped right after lk_done is sampled
`timescale 1ns/10ps
module link_port (
   // clocks and reset
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic link_clk,
   // link side
   input wire logic lk_req,
   input wire logic lk_wr,
   input wire logic [7:0] lk_addr,
   input wire logic [31:0] lk_wdata,
   output logic [31:0] lk_rdata,
   output logic lk_done,
   output logic lk_busy,
   // system side
   output logic acc_valid,
   output logic acc_wr,
   output logic [7:0] acc_addr,
   output logic [31:0] acc_wdata,
   input wire logic [31:0] acc_rdata
);
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic req_tgl;
      logic ack_s1;
      logic ack_s2;
      logic ack_seen;
      logic busy;
      logic done;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
   } lnk_type;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic valid;
      logic ack_tgl;
      logic [31:0] hold;
   } sys_type;

   lnk_type lq;
   lnk_type ld;
   sys_type sq;
   sys_type sd;

   always_comb begin
      ld = lq;
      ld.done = 1'b0;
      ld.rst_s1 = srst;
      ld.rst_s2 = lq.rst_s1;
      ld.ack_s1 = sq.ack_tgl;
      ld.ack_s2 = lq.ack_s1;
      if (lq.busy && (lq.ack_s2 != lq.ack_seen)) begin
         ld.ack_seen = lq.ack_s2;
         ld.rdata = sq.hold;
         ld.done = 1'b1;
         ld.busy = 1'b0;
      end else if (lk_req && !lq.busy && !lq.done) begin
         // no take while done stands: the host still holds its request there
         ld.wr = lk_wr;
         ld.addr = lk_addr;
         ld.wdata = lk_wdata;
         ld.req_tgl = ~lq.req_tgl;
         ld.busy = 1'b1;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lq.rst_s2) begin
         lq <= '{rst_s1: ld.rst_s1, rst_s2: ld.rst_s2, default: '0};
      end else begin
         lq <= ld;
      end
   end

   always_comb begin
      sd = sq;
      sd.req_s1 = lq.req_tgl;
      sd.req_s2 = sq.req_s1;
      sd.valid = 1'b0;
      if (sq.req_s2 != sq.req_seen) begin
         sd.req_seen = sq.req_s2;
         sd.valid = 1'b1;
      end
      if (sq.valid) begin
         sd.hold = acc_rdata;
         sd.ack_tgl = ~sq.ack_tgl;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sq <= '0;
      end else begin
         sq <= sd;
      end
   end

   // link request fields are stable while busy, so read directly
   assign acc_valid = sq.valid;
   assign acc_wr = lq.wr;
   assign acc_addr = lq.addr;
   assign acc_wdata = lq.wdata;
   assign lk_rdata = lq.rdata;
   assign lk_done = lq.done;
   assign lk_busy = lq.busy;
endmodule

/* rtl/meas_engine.sv */
// conversion engine: raw shunt/bus codes in, shunt, bus, current, power out
// assumes adc samples on clk_sys spaced at least two cycles apart
`timescale 1ns/10ps
`include "quad_monitor_map.svh"
module meas_engine #(
   parameter int CH = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // conversion results
   input wire logic adc_valid,
   input wire logic adc_bus,
   input wire logic [1:0] adc_chan,
   input wire logic [15:0] adc_code,
   // per channel calibration scale
   input wire logic [CH-1:0][15:0] cal,
   // measurement stream
   meas_if.src m
);
   import quad_monitor_pkg::*;

   typedef struct packed {
      eng_state_type st;
      logic [1:0] chan;
      logic [15:0] code;
      logic [CH-1:0][15:0] cur;
      logic o_valid;
      meas_kind_type o_kind;
      logic [15:0] o_value;
   } eng_type;

   eng_type q;
   eng_type d;

   always_comb begin
      logic signed [31:0] prod;
      logic [16:0] mag;
      logic [48:0] pw;
      prod = '0;
      mag = '0;
      pw = '0;
      d = q;
      d.o_valid = 1'b0;
      d.o_kind = MEAS_NONE;
      case (q.st)
         ENG_IDLE: begin
            if (adc_valid) begin
               d.chan = adc_chan;
               d.code = adc_code;
               d.o_valid = 1'b1;
               d.o_value = adc_code;
               d.o_kind = adc_bus ? MEAS_BUS : MEAS_SHUNT;
               d.st = adc_bus ? ENG_POWER : ENG_CURRENT;
            end
         end
         ENG_CURRENT: begin
            // signed shunt times scale; a zero scale yields zero [RULE14] [RULE10]
            prod = $signed(q.code) * $signed({1'b0, cal[q.chan]});
            d.cur[q.chan] = (cal[q.chan] == 16'h0000) ? 16'h0000 :
               prod[`CUR_SHIFT +: 16];
            d.o_valid = 1'b1;
            d.o_kind = MEAS_CURRENT;
            d.o_value = d.cur[q.chan];
            d.st = ENG_IDLE;
         end
         ENG_POWER: begin
            // unsigned power from |current| and bus code [RULE13] [RULE12]
            mag = q.cur[q.chan][15] ? 17'(-$signed({q.cur[q.chan][15], q.cur[q.chan]})) :
               {1'b0, q.cur[q.chan]};
            pw = 49'(mag) * 49'(q.code) * 49'(`PWR_MUL);
            d.o_valid = 1'b1;
            d.o_kind = MEAS_POWER;
            d.o_value = (pw[48:46] != 3'h0) ? 16'hFFFF : pw[`PWR_SHIFT +: 16];
            d.st = ENG_IDLE;
         end
         default: d.st = ENG_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q <= '{st: ENG_IDLE, o_kind: MEAS_NONE, default: '0};
      end else begin
         q <= d;
      end
   end

   assign m.valid = q.o_valid;
   assign m.kind = q.o_kind;
   assign m.chan = q.chan;
   assign m.value = q.o_value;
endmodule

/* rtl/quad_monitor.sv */
// four-channel monitor: alert threshold logic and channel 1 results
// assumes raw conversion codes arrive on clk_sys from the converter,
// register access arrives on link_clk, en_pin comes from a board pin
//
// Behaviour
// (RULE1) The alert pin is driven only for the fault chosen in each alert configuration.
// (RULE2) Host-written thresholds are compared against the chosen measurement.
// (RULE3) The channel field is binary coded, 00 meaning channel 1.
// (RULE4) Fault code 001 trips when shunt voltage exceeds the threshold (overcurrent).
// (RULE5) Fault code 011 trips when bus voltage exceeds the threshold.
// (RULE6) Shunt thresholds are raw shunt counts and are compared count to count.
// (RULE7) All four thresholds return to defaults while disabled or after reset.
// (RULE8) Each threshold and configuration pair may watch any of the four channels.
// (RULE9) Result registers hold raw integer counts scaled by the step size.
// (RULE10) Shunt and current results are two's complement.
// (RULE11) The alert follows a completed conversion within a few clock cycles.
// (RULE12) Over-power alerts follow the power computation, well inside the extra 60 us.
// (RULE13) Power is an unsigned 16-bit count and energy an unsigned sum of power.
// (RULE14) A zero calibration scale gives a zero current.
// (RULE15) Bus voltage compares unsigned; shunt voltage compares signed.
// (RULE16) Each alert is re-evaluated per matching conversion and held while it persists.
`timescale 1ns/10ps
`include "quad_monitor_map.svh"
module quad_monitor #(
   parameter int CH = 4,
   parameter logic [15:0] THRESH_DEFAULT = `THRESH_RST
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // link register port
   input wire logic link_clk,
   input wire logic lk_req,
   input wire logic lk_wr,
   input wire logic [7:0] lk_addr,
   input wire logic [31:0] lk_wdata,
   output logic [31:0] lk_rdata,
   output logic lk_done,
   output logic lk_busy,
   // device enable pin
   input wire logic en_pin,
   // converter results
   input wire logic adc_valid,
   input wire logic adc_bus,
   input wire logic [1:0] adc_chan,
   input wire logic [15:0] adc_code,
   // open-drain alert pin
   output logic alert_out,
   output logic alert_oe
);
   import quad_monitor_pkg::*;

   typedef struct packed {
      logic en_s1;
      logic en_s2;
      logic [CH-1:0][15:0] cal;
      alert_cfg_type [CH-1:0] cfg;
      logic [CH-1:0][15:0] thr;
      logic [CH-1:0] act;
      logic [15:0] shunt1;
      logic [15:0] rail1;
      logic [15:0] cur1;
      logic [15:0] pwr1;
      logic [31:0] energy1;
      logic alert_oe;
      logic alert_lvl;
   } state_type;

   state_type q;
   state_type d;

   logic acc_valid;
   logic acc_wr;
   logic [7:0] acc_addr;
   logic [31:0] acc_wdata;
   logic [31:0] acc_rdata;

   meas_if m ();

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   link_port u_link (
      .clk_sys(clk_sys),
      .srst(srst),
      .link_clk(link_clk),
      .lk_req(lk_req),
      .lk_wr(lk_wr),
      .lk_addr(lk_addr),
      .lk_wdata(lk_wdata),
      .lk_rdata(lk_rdata),
      .lk_done(lk_done),
      .lk_busy(lk_busy),
      .acc_valid(acc_valid),
      .acc_wr(acc_wr),
      .acc_addr(acc_addr),
      .acc_wdata(acc_wdata),
      .acc_rdata(acc_rdata)
   );

   meas_engine #(
      .CH(CH)
   ) u_engine (
      .clk_sys(clk_sys),
      .srst(srst),
      .adc_valid(adc_valid && q.en_s2),
      .adc_bus(adc_bus),
      .adc_chan(adc_chan),
      .adc_code(adc_code),
      .cal(q.cal),
      .m(m.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decoding functions

   // which measurement a fault selection watches
   function automatic meas_kind_type watched_kind(input fault_sel_type f);
      case (f)
         FAULT_SHUNT_OVER: watched_kind = MEAS_SHUNT;
         FAULT_SHUNT_UNDER: watched_kind = MEAS_SHUNT;
         FAULT_BUS_OVER: watched_kind = MEAS_BUS;
         FAULT_BUS_UNDER: watched_kind = MEAS_BUS;
         FAULT_POWER_OVER: watched_kind = MEAS_POWER;
         default: watched_kind = MEAS_NONE;
      endcase
   endfunction

   // threshold comparison for one fault selection
   function automatic logic tripped(
      input fault_sel_type f,
      input logic [15:0] v,
      input logic [15:0] t
   );
      case (f)
         FAULT_SHUNT_OVER: tripped = $signed(v) > $signed(t); // [RULE4] [RULE6]
         FAULT_SHUNT_UNDER: tripped = $signed(v) < $signed(t); // [RULE15]
         FAULT_BUS_OVER: tripped = v > t; // [RULE5] [RULE15]
         FAULT_BUS_UNDER: tripped = v < t;
         FAULT_POWER_OVER: tripped = v > t; // [RULE12]
         default: tripped = 1'b0;
      endcase
   endfunction

   // register file read decode
   function automatic logic [31:0] reg_read(input state_type s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         `REG_SHUNT_CH1: r = {16'h0000, s.shunt1};
         `REG_RAIL_CH1: r = {16'h0000, s.rail1};
         `REG_CH1_CURRENT_RESULT: r = {16'h0000, s.cur1};
         `REG_CH1_POWER_RESULT: r = {16'h0000, s.pwr1};
         `REG_CH1_ENERGY_ACCUMULATOR: r = s.energy1;
         `REG_ALERT_STATUS: r = {27'h000_0000, s.act, s.en_s2};
         default: r = 32'h0000_0000;
      endcase
      for (int i = 0; i < CH; i++) begin
         if (a == `REG_CAL_BASE + 8'(i)) begin
            r = {16'h0000, s.cal[i]};
         end
         if (a == `REG_ALERT_CFG_BASE + 8'(i)) begin
            r[`CFG_FAULT_LSB +: 3] = s.cfg[i].fault;
            r[`CFG_CHAN_LSB +: 2] = s.cfg[i].chan;
         end
         if (a == `REG_THRESH_BASE + 8'(i)) begin
            r = {16'h0000, s.thr[i]};
         end
      end
      reg_read = r;
   endfunction

   assign acc_rdata = reg_read(q, acc_addr);

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic hit;
      hit = 1'b0;
      d = q;
      d.en_s1 = en_pin;
      d.en_s2 = q.en_s1;

      // register writes
      if (acc_valid && acc_wr) begin
         for (int i = 0; i < CH; i++) begin
            if (acc_addr == `REG_CAL_BASE + 8'(i)) begin
               d.cal[i] = acc_wdata[15:0];
            end
            if (acc_addr == `REG_ALERT_CFG_BASE + 8'(i)) begin
               d.cfg[i].fault = fault_sel_type'(acc_wdata[`CFG_FAULT_LSB +: 3]);
               d.cfg[i].chan = acc_wdata[`CFG_CHAN_LSB +: 2];
            end
            if (acc_addr == `REG_THRESH_BASE + 8'(i)) begin
               d.thr[i] = acc_wdata[15:0]; // [RULE2]
            end
         end
      end

      // channel 1 results kept as raw counts
      if (m.valid && (m.chan == `CHAN_CH1)) begin
         case (m.kind)
            MEAS_SHUNT: d.shunt1 = m.value; // [RULE9] [RULE10]
            MEAS_BUS: d.rail1 = m.value; // [RULE15]
            MEAS_CURRENT: d.cur1 = m.value; // [RULE10]
            MEAS_POWER: begin
               d.pwr1 = m.value; // [RULE13]
               d.energy1 = q.energy1 + {16'h0000, m.value}; // [RULE13]
            end
            default: d.shunt1 = q.shunt1;
         endcase
      end

      // alert evaluation, one slot per threshold
      for (int i = 0; i < CH; i++) begin
         if (q.cfg[i].fault == FAULT_NONE) begin
            d.act[i] = 1'b0; // [RULE1]
         end else if (m.valid && (m.chan == q.cfg[i].chan) && // [RULE3] [RULE8]
            (m.kind == watched_kind(q.cfg[i].fault))) begin // [RULE1]
            // re-evaluated each matching conversion, held in between
            d.act[i] = tripped(q.cfg[i].fault, m.value, q.thr[i]); // [RULE16] [RULE2]
         end
      end

      // disabled: thresholds back to defaults, alerts dropped
      if (!q.en_s2) begin
         for (int i = 0; i < CH; i++) begin
            d.thr[i] = THRESH_DEFAULT; // [RULE7]
         end
         d.act = '0;
      end

      hit = |d.act;
      d.alert_oe = hit; // [RULE11]
      d.alert_lvl = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q <= '0;
         for (int i = 0; i < CH; i++) begin
            q.thr[i] <= THRESH_DEFAULT; // [RULE7]
            q.cal[i] <= `CAL_RST;
         end
      end else begin
         q <= d;
      end
   end

   assign alert_out = q.alert_lvl;
   assign alert_oe = q.alert_oe;
endmodule

/* shared/meas_if.sv */
// measurement stream from the conversion engine to the alert logic
// assumes both ends on clk_sys
`timescale 1ns/10ps
interface meas_if;
   import quad_monitor_pkg::*;
   logic valid;
   meas_kind_type kind;
   logic [1:0] chan;
   logic [15:0] value;
   modport src (output valid, output kind, output chan, output value);
   modport dst (input valid, input kind, input chan, input value);
endinterface

/* shared/quad_monitor_map.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from any design file
`ifndef QUAD_MONITOR_MAP_SVH
`define QUAD_MONITOR_MAP_SVH

// channel 1 result registers
`define REG_SHUNT_CH1 8'h00
`define REG_RAIL_CH1 8'h01
`define REG_CH1_CURRENT_RESULT 8'h02
`define REG_CH1_POWER_RESULT 8'h03
`define REG_CH1_ENERGY_ACCUMULATOR 8'h04
// calibration, alert configuration, thresholds (four each), status
`define REG_CAL_BASE 8'h05
`define REG_ALERT_CFG_BASE 8'h09
`define REG_THRESH_BASE 8'h0D
`define REG_ALERT_STATUS 8'h11

// alert configuration fields
`define CFG_FAULT_LSB 0
`define CFG_CHAN_LSB 4
`define CHAN_CH1 2'h0

// reset values
`define THRESH_RST 16'h7FFF
`define CAL_RST 16'h0000

// arithmetic scaling
`define SHUNT_STEP_NV 2500
`define CUR_SHIFT 11
`define PWR_MUL 16'hD1B7
`define PWR_SHIFT 30
`define PWR_LSB_MULT 32

// timing
`define CLK_MHZ 50
`define POWER_EXTRA_US 60
`define POWER_EXTRA_CYC (`POWER_EXTRA_US * `CLK_MHZ)

`endif

/* shared/quad_monitor_pkg.sv */
// types shared by the monitor alert block and its helpers
// assumes nothing beyond a SystemVerilog compiler
package quad_monitor_pkg;

   typedef enum logic [2:0] {
      FAULT_NONE = 3'h0,
      FAULT_SHUNT_OVER = 3'h1,
      FAULT_SHUNT_UNDER = 3'h2,
      FAULT_BUS_OVER = 3'h3,
      FAULT_BUS_UNDER = 3'h4,
      FAULT_POWER_OVER = 3'h5
   } fault_sel_type;

   typedef enum logic [3:0] {
      MEAS_NONE = 4'h0,
      MEAS_SHUNT = 4'h1,
      MEAS_BUS = 4'h2,
      MEAS_CURRENT = 4'h4,
      MEAS_POWER = 4'h8
   } meas_kind_type;

   typedef struct packed {
      logic [1:0] chan;
      fault_sel_type fault;
   } alert_cfg_type;

   typedef enum logic [2:0] {
      ENG_IDLE = 3'b001,
      ENG_CURRENT = 3'b010,
      ENG_POWER = 3'b100
   } eng_state_type;

endpackage

/* tb/link_host.sv */
// host model on the link register port
// assumes link_clk runs free; one access outstanding at a time
`timescale 1ns/10ps
module link_host (
   // link clock
   input wire logic link_clk,
   // request
   output logic lk_req,
   output logic lk_wr,
   output logic [7:0] lk_addr,
   output logic [31:0] lk_wdata,
   // answer
   input wire logic [31:0] lk_rdata,
   input wire logic lk_done,
   input wire logic lk_busy
);
   initial begin
      lk_req = 1'b0;
      lk_wr = 1'b1;
      lk_addr = 8'hFF;
      lk_wdata = 32'hFFFF_FFFF;
   end
   // whole word access, held until done is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ok);
      int n;
      @(posedge link_clk);
      #1;
      lk_req = 1'b1;
      lk_wr = w;
      lk_addr = a;
      lk_wdata = d;
      n = 0;
      do begin
         @(posedge link_clk);
         n++;
      end while (lk_done !== 1'b1 && n < 12);
      q = lk_rdata;
      ok = lk_done;
      #1;
      // released lines show no stale value
      lk_req = 1'b0;
      lk_wr = ~w;
      lk_addr = ~a;
      lk_wdata = ~d;
   endtask
endmodule

/* tb/quad_monitor_properties.sv */
// concurrent checks on the alert pin and the link register port
// assumes binding to quad_monitor with both clocks running
`timescale 1ns/10ps
module quad_monitor_properties (
   // clocks and reset
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic link_clk,
   // link port
   input wire logic lk_req,
   input wire logic lk_done,
   input wire logic lk_busy,
   // enable, conversions, alert
   input wire logic en_pin,
   input wire logic adc_valid,
   input wire logic alert_out,
   input wire logic alert_oe
);
////////////////////////////////////////////////////////////////////////////////
   a_pin_low_only: assert property (@(posedge clk_sys) disable iff (srst)
      !alert_out) else $error("alert pin driven high");
   a_disable_clears: assert property (@(posedge clk_sys) disable iff (srst)
      !en_pin [*5] |-> !alert_oe) else $error("alert held while disabled");
   a_rise_after_conv: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(alert_oe) |-> $past(adc_valid, 2) || $past(adc_valid, 3))
      else $error("alert rose without a conversion");
////////////////////////////////////////////////////////////////////////////////
   a_busy_after_take: assert property (@(posedge link_clk) disable iff (srst)
      lk_req && !lk_busy && !lk_done |=> lk_busy) else $error("request not taken");
   a_done_in_time: assert property (@(posedge link_clk) disable iff (srst)
      lk_req && !lk_busy && !lk_done |-> ##[3:5] lk_done) else $error("access not answered");
   a_done_single: assert property (@(posedge link_clk) disable iff (srst)
      lk_done |=> !lk_done) else $error("done longer than one cycle");
   a_busy_ends_done: assert property (@(posedge link_clk) disable iff (srst)
      $fell(lk_busy) |-> lk_done) else $error("busy fell without done");
   a_done_needs_busy: assert property (@(posedge link_clk) disable iff (srst)
      $rose(lk_done) |-> $past(lk_busy)) else $error("done without access");
   c_alert_rise: cover property (@(posedge clk_sys) disable iff (srst) $rose(alert_oe));
   c_alert_fall: cover property (@(posedge clk_sys) disable iff (srst) $fell(alert_oe));
   c_link_done: cover property (@(posedge link_clk) disable iff (srst) lk_done);
endmodule

bind quad_monitor quad_monitor_properties chk (
   .clk_sys(clk_sys),
   .srst(srst),
   .link_clk(link_clk),
   .lk_req(lk_req),
   .lk_done(lk_done),
   .lk_busy(lk_busy),
   .en_pin(en_pin),
   .adc_valid(adc_valid),
   .alert_out(alert_out),
   .alert_oe(alert_oe)
);

/* tb/testbench.sv */
// self-checking bench for the quad monitor alert block
// assumes link_host model and the bound property checker
`timescale 1ns/10ps
`include "quad_monitor_map.svh"
module testbench;
   logic clk_sys = 1'b0;
   logic link_clk = 1'b0;
   logic srst = 1'b1;
   logic en_pin = 1'b1;
   logic adc_valid = 1'b0;
   logic adc_bus = 1'b0;
   logic [1:0] adc_chan = 2'h0;
   logic [15:0] adc_code = 16'h0000;
   logic lk_req, lk_wr, lk_done, lk_busy, alert_out, alert_oe;
   logic [7:0] lk_addr;
   logic [31:0] lk_wdata, lk_rdata;
   int mismatches = 0;
   int n_checks = 0;
   localparam logic [63:0] PWR = (64'h4B00 * 64'h1D4C * `PWR_MUL) >> `PWR_SHIFT;

   always #10 clk_sys = ~clk_sys;
   initial begin
      #37;
      forever #80 link_clk = ~link_clk;
   end

   quad_monitor uut (
      .clk_sys(clk_sys), .srst(srst), .link_clk(link_clk), .lk_req(lk_req),
      .lk_wr(lk_wr), .lk_addr(lk_addr), .lk_wdata(lk_wdata), .lk_rdata(lk_rdata),
      .lk_done(lk_done), .lk_busy(lk_busy), .en_pin(en_pin), .adc_valid(adc_valid),
      .adc_bus(adc_bus), .adc_chan(adc_chan), .adc_code(adc_code),
      .alert_out(alert_out), .alert_oe(alert_oe)
   );
   link_host host (
      .link_clk(link_clk), .lk_req(lk_req), .lk_wr(lk_wr), .lk_addr(lk_addr),
      .lk_wdata(lk_wdata), .lk_rdata(lk_rdata), .lk_done(lk_done), .lk_busy(lk_busy)
   );
////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic link(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      logic ok;
      host.xfer(w, a, d, q, ok);
      if (ok !== 1'b1) begin
         mismatches++;
         $display("wrong value lk_done expected 1 seen %b", ok);
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      link(1'b1, a, d, q);
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      link(1'b0, a, 32'h0000_0000, q);
      chk(n, e, q);
   endtask
   // one conversion, alert judged the stated number of edges later
   task automatic conv(input logic b, input logic [1:0] c, input logic [15:0] v,
      input int lat, input logic e);
      @(posedge clk_sys);
      #1;
      adc_valid = 1'b1;
      adc_bus = b;
      adc_chan = c;
      adc_code = v;
      @(posedge clk_sys);
      #1;
      adc_valid = 1'b0;
      adc_code = ~v;
      repeat (lat) @(posedge clk_sys);
      #1;
      chk("alert_oe", {31'h0, e}, {31'h0, alert_oe});
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      for (int i = 0; i < 4; i++) begin
         rd("threshold", `REG_THRESH_BASE + 8'(i), {16'h0000, `THRESH_RST});
         rd("alert_cfg", `REG_ALERT_CFG_BASE + 8'(i), 32'h0000_0000);
      end
      wr(8'h30, 32'h1234_5678);
      rd("unmapped", 8'h30, 32'h0000_0000);
   endtask
   task automatic t_shunt_over;
      wr(`REG_THRESH_BASE, 32'h0000_7080);
      wr(`REG_ALERT_CFG_BASE, 32'h0000_0001);
      conv(1'b0, 2'h0, 16'h7081, 3, 1'b1);
      rd("shunt_result", `REG_SHUNT_CH1, 32'h0000_7081);
      conv(1'b0, 2'h0, 16'h7080, 3, 1'b0);
      conv(1'b0, 2'h0, 16'h7081, 3, 1'b1);
      conv(1'b0, 2'h1, 16'h0000, 3, 1'b1);
      conv(1'b0, 2'h0, 16'h8000, 3, 1'b0);
      rd("shunt_result", `REG_SHUNT_CH1, 32'h0000_8000);
      wr(`REG_ALERT_CFG_BASE, 32'h0000_0002);
      conv(1'b0, 2'h0, 16'h8000, 3, 1'b1);
      conv(1'b0, 2'h0, 16'h7080, 3, 1'b0);
      wr(`REG_ALERT_CFG_BASE, 32'h0000_0001);
   endtask
   task automatic t_bus_over;
      wr(`REG_THRESH_BASE + 8'h01, 32'h0000_1D4C);
      wr(`REG_ALERT_CFG_BASE + 8'h01, 32'h0000_0003);
      conv(1'b1, 2'h0, 16'h1D4D, 3, 1'b1);
      rd("rail_result", `REG_RAIL_CH1, 32'h0000_1D4D);
      conv(1'b1, 2'h0, 16'h1D4C, 3, 1'b0);
      wr(`REG_ALERT_CFG_BASE + 8'h01, 32'h0000_0004);
      conv(1'b1, 2'h0, 16'hFFFF, 3, 1'b0);
      wr(`REG_ALERT_CFG_BASE + 8'h01, 32'h0000_0000);
   endtask
   task automatic t_power;
      conv(1'b0, 2'h0, 16'h4B00, 3, 1'b0);
      rd("current_result", `REG_CH1_CURRENT_RESULT, 32'h0000_0000);
      wr(`REG_CAL_BASE, 32'h0000_0800);
      conv(1'b0, 2'h0, 16'h4B00, 3, 1'b0);
      rd("current_result", `REG_CH1_CURRENT_RESULT, 32'h0000_4B00);
      wr(`REG_THRESH_BASE + 8'h02, PWR[31:0] - 32'h0000_0001);
      wr(`REG_ALERT_CFG_BASE + 8'h02, 32'h0000_0005);
      conv(1'b1, 2'h0, 16'h1D4C, 4, 1'b1);
      rd("power_result", `REG_CH1_POWER_RESULT, PWR[31:0]);
      rd("energy_result", `REG_CH1_ENERGY_ACCUMULATOR, PWR[31:0]);
      conv(1'b0, 2'h0, 16'hFF00, 3, 1'b1);
      rd("current_result", `REG_CH1_CURRENT_RESULT, 32'h0000_FF00);
      rd("alert_status", `REG_ALERT_STATUS, 32'h0000_0009);
   endtask
   task automatic t_disable;
      wr(`REG_THRESH_BASE, 32'h0000_0100);
      @(posedge clk_sys);
      #1;
      en_pin = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      chk("alert_oe", 32'h0000_0000, {31'h0, alert_oe});
      wr(`REG_THRESH_BASE + 8'h01, 32'h0000_0123);
      @(posedge clk_sys);
      #1;
      en_pin = 1'b1;
      rd("threshold", `REG_THRESH_BASE, {16'h0000, `THRESH_RST});
      rd("threshold", `REG_THRESH_BASE + 8'h01, {16'h0000, `THRESH_RST});
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (34) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      repeat (3) @(posedge link_clk);
      t_defaults();
      t_shunt_over();
      t_bus_over();
      t_power();
      t_disable();
      report_and_stop();
   end
endmodule
